// ---- rtl/dav_unit.sv ----
// Draw-and-advance execution datapath with two register files
// Assumes the frame buffer takes a pixel write when wr_ready is high
//
// Operation
// - Write one foreground-colour pixel at the XY address in destination.
// - After the write, destination becomes destination plus increment.
// - Increment and address both come from file A or both from B.
// - XY operand: y in upper half-word, x in lower half-word.
// - Origin upper left; x grows right, y grows downward.
// - Pixel sized by pixel size; plane mask applied to each write.
// - XY address converted with pitch, offset and pitch conversion.
module dav_unit
  import dav_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              start,
  input  wire logic              file_sel,
  input  wire logic [3:0]        src_idx,
  input  wire logic [3:0]        dst_idx,
  input  wire logic              reg_we,
  input  wire logic              reg_we_file,
  input  wire logic [3:0]        reg_we_idx,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic [31:0]       foreground_colour_reg,
  input  wire dav_pkg::dav_fmt_t fmt,
  input  wire logic              wr_ready,
  output dav_pkg::dav_pix_t      wr_pix,
  output logic                   wr_valid,
  output logic                   busy,
  output logic                   done,
  output logic [31:0]            rd_a_dst,
  output logic [31:0]            rd_b_dst
);
  import dav_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_WRITE, S_ADV} dav_state_t;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] file_a_r [DAV_REG_NUM];
  logic [31:0] file_b_r [DAV_REG_NUM];
  dav_state_t  state_r;
  dav_state_t  state_nxt;
  logic        sel_r;
  logic [3:0]  src_r;
  logic [3:0]  dst_r;
  dav_pix_t    pix_r;
  logic        done_r;

  // Add x and y halves without carry between them
  function automatic logic [31:0] xy_add(input logic [31:0] a,
                                         input logic [31:0] b);
    xy_add = {a[31:16] + b[31:16], a[15:0] + b[15:0]};
  endfunction : xy_add

  // Both operands from the one selected file
  function automatic logic [31:0] pick_file(input logic        sel,
                                            input logic [31:0] a_val,
                                            input logic [31:0] b_val);
    pick_file = sel ? b_val : a_val;
  endfunction : pick_file

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  wire in_idle;
  wire in_write;
  wire in_adv;
  wire take_start;
  wire take_write;
  wire take_load;

  assign in_idle    = (state_r == S_IDLE);
  assign in_write   = (state_r == S_WRITE);
  assign in_adv     = (state_r == S_ADV);
  assign take_start = in_idle && start;
  assign take_write = in_write && wr_ready;
  assign take_load  = in_idle && reg_we;

  // ----------------------------------------------------------------
  // Operand selection
  // ----------------------------------------------------------------
  wire [31:0]   a_dst;
  wire [31:0]   a_src;
  wire [31:0]   b_dst;
  wire [31:0]   b_src;
  wire [31:0]   dst_val;
  wire [31:0]   inc_val;
  wire [31:0]   adv_val;
  wire [31:0]   lin_addr;
  wire [31:0]   mask32;
  wire dav_xy_t dst_xy;

  assign a_dst   = file_a_r[dst_r];
  assign a_src   = file_a_r[src_r];
  assign b_dst   = file_b_r[dst_r];
  assign b_src   = file_b_r[src_r];
  assign dst_val = pick_file(sel_r, a_dst, b_dst);
  assign inc_val = pick_file(sel_r, a_src, b_src);
  assign dst_xy  = dav_xy_t'(dst_val);
  assign adv_val = xy_add(dst_val, inc_val);
  assign mask32  = {fmt.plane_mask, fmt.plane_mask};

  dav_xy_conv u_conv (
    .xy         (dst_xy),
    .pitch_conv (fmt.pitch_conv),
    .pixel_size (fmt.pixel_size),
    .offset     (fmt.offset),
    .lin_addr   (lin_addr)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE:  if (take_start) state_nxt = S_WRITE;
      S_WRITE: if (take_write) state_nxt = S_ADV;
      S_ADV:   state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) state_r <= S_IDLE;
    else state_r <= state_nxt;
  end

  // Operands held for the whole instruction
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sel_r <= 1'b0;
      src_r <= 4'h0;
      dst_r <= 4'h0;
    end else if (take_start) begin
      sel_r <= file_sel;
      src_r <= src_idx;
      dst_r <= dst_idx;
    end
  end

  // Completion pulse one cycle after the advance
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) done_r <= 1'b0;
    else done_r <= in_adv;
  end

  // ----------------------------------------------------------------
  // Pixel write
  // ----------------------------------------------------------------
  dav_pix_t pix_cap;
  always_comb begin
    pix_cap      = '0;
    pix_cap.addr = lin_addr;
    pix_cap.data = foreground_colour_reg;
    pix_cap.mask = mask32;
    pix_cap.size = fmt.pixel_size;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pix_r <= '0;
    end else if (in_idle) begin
      pix_r <= pix_cap;
    end
  end

  // ----------------------------------------------------------------
  // Register files
  // ----------------------------------------------------------------
  wire        adv_a;
  wire        adv_b;
  wire        load_a;
  wire        load_b;
  wire        a_we;
  wire        b_we;
  wire [3:0]  wr_idx;
  wire [31:0] wr_data;

  // Advance and load never meet: loads land only while idle
  assign adv_a   = in_adv && !sel_r;
  assign adv_b   = in_adv && sel_r;
  assign load_a  = take_load && !reg_we_file;
  assign load_b  = take_load && reg_we_file;
  assign a_we    = adv_a || load_a;
  assign b_we    = adv_b || load_b;
  assign wr_idx  = in_adv ? dst_r : reg_we_idx;
  assign wr_data = in_adv ? adv_val : reg_wdata;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DAV_REG_NUM; i++) begin
        file_a_r[i] <= DAV_REG_RST;
      end
    end else if (a_we) begin
      file_a_r[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DAV_REG_NUM; i++) begin
        file_b_r[i] <= DAV_REG_RST;
      end
    end else if (b_we) begin
      file_b_r[wr_idx] <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Address follows the latched destination during the write
  dav_pix_t pix_live;
  always_comb begin
    pix_live      = pix_r;
    pix_live.addr = lin_addr;
  end

  assign wr_pix   = pix_live;
  assign wr_valid = in_write;
  assign busy     = !in_idle;
  assign done     = done_r;
  assign rd_a_dst = file_a_r[dst_idx];
  assign rd_b_dst = file_b_r[dst_idx];
endmodule : dav_unit

// ---- rtl/dav_pkg.sv ----
// Package for the draw-and-advance pixel unit
// Assumes a single processor clock domain
package dav_pkg;

  localparam int DAV_DATA_W  = 32;
  localparam int DAV_HALF_W  = 16;
  localparam int DAV_REG_NUM = 15;
  localparam int DAV_IDX_W   = 4;
  localparam int DAV_PITCH_W = 5;

  localparam logic [31:0] DAV_REG_RST   = 32'h0000_0000;
  localparam logic [15:0] DAV_MASK_RST  = 16'h0000;
  localparam logic [5:0]  DAV_PIXEL_SIZE_REG_RST = 6'h01;

  // XY field positions: y in upper half, x in lower half
  localparam int DAV_X_LSB = 0;
  localparam int DAV_Y_LSB = 16;

  typedef struct packed {
    logic [15:0] y;
    logic [15:0] x;
  } dav_xy_t;

  // Screen-memory format set by software
  typedef struct packed {
    logic [31:0] offset;
    logic [4:0]  pitch_conv;
    logic [5:0]  pixel_size;
    logic [15:0] plane_mask;
  } dav_fmt_t;

  // Pixel write toward the frame buffer
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [31:0] mask;
    logic [5:0]  size;
  } dav_pix_t;

endpackage : dav_pkg

// ---- rtl/dav_xy_conv.sv ----
// XY to linear bit address conversion
// Assumes pitch is a power of two given as a shift count
module dav_xy_conv
  import dav_pkg::*;
(
  input  wire dav_pkg::dav_xy_t xy,
  input  wire logic [4:0]       pitch_conv,
  input  wire logic [5:0]       pixel_size,
  input  wire logic [31:0]      offset,
  output logic [31:0]           lin_addr
);
  wire [31:0] row_addr;
  wire [31:0] col_addr;

  // Origin upper left, y down, x right
  assign row_addr = {16'h0000, xy.y} << pitch_conv;
  assign col_addr = {16'h0000, xy.x} * {26'h0000000, pixel_size};
  assign lin_addr = offset + row_addr + col_addr;
endmodule : dav_xy_conv

// ---- testbench/dav_unit_asserts.sv ----
// Checker for the draw-and-advance unit
// Assumes operands and format stay put while busy
module dav_chk
  import dav_pkg::*;
(
  input wire logic              mclk,
  input wire logic              arst_n,
  input wire logic              start,
  input wire logic              file_sel,
  input wire logic              wr_ready,
  input wire logic [31:0]       foreground_colour_reg,
  input wire dav_pkg::dav_fmt_t fmt,
  input wire dav_pkg::dav_pix_t wr_pix,
  input wire logic              wr_valid,
  input wire logic              busy,
  input wire logic              done,
  input wire logic [31:0]       rd_a_dst,
  input wire logic [31:0]       rd_b_dst
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic [31:0] xy;
  assign xy = file_sel ? rd_b_dst : rd_a_dst;
  sequence s_take;
    wr_valid && wr_ready;
  endsequence
  sequence s_finish;
    ##1 !done ##1 (done && !busy);
  endsequence
  a_start_write: assert property (start && !busy |=> wr_valid && busy)
    else $error("no write after start");
  a_write_hold: assert property (wr_valid && !wr_ready |=> wr_valid)
    else $error("write dropped");
  a_pix_colour: assert property (
    wr_valid |-> wr_pix.data == foreground_colour_reg)
    else $error("pixel colour wrong");
  a_take_done: assert property (s_take |-> s_finish)
    else $error("no done after write");
  a_done_pulse: assert property (done |=> !done)
    else $error("done too long");
  a_one_file: assert property (
    busy |=> (file_sel ? $stable(rd_a_dst) : $stable(rd_b_dst)))
    else $error("other file changed");
  a_pix_mask: assert property (
    wr_valid |-> wr_pix.mask == {2{fmt.plane_mask}} &&
                 wr_pix.size == fmt.pixel_size)
    else $error("mask or size wrong");
  a_xy_addr: assert property (
    wr_valid |-> wr_pix.addr == fmt.offset +
      (32'(xy[31:16]) << fmt.pitch_conv) +
      32'(xy[15:0]) * 32'(fmt.pixel_size))
    else $error("address wrong");
endmodule : dav_chk

bind dav_unit dav_chk chk_u (.mclk(mclk), .arst_n(arst_n), .start(start),
  .file_sel(file_sel), .wr_ready(wr_ready), .fmt(fmt), .wr_pix(wr_pix),
  .foreground_colour_reg(foreground_colour_reg), .wr_valid(wr_valid),
  .busy(busy), .done(done), .rd_a_dst(rd_a_dst), .rd_b_dst(rd_b_dst));

// ---- testbench/dav_fb_model.sv ----
// Frame buffer model taking pixel writes
// Assumes stall is held while a write is pending
module dav_fb_model
  import dav_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic [1:0]        stall,
  input  wire logic              wr_valid,
  input  wire dav_pkg::dav_pix_t wr_pix,
  output logic                   wr_ready,
  output dav_pkg::dav_pix_t      last_r
);
  logic [1:0] wait_r;
  assign wr_ready = wr_valid && (wait_r == stall);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) {wait_r, last_r} <= '0;
    else if (wr_ready) {wait_r, last_r} <= {2'h0, wr_pix};
    else if (wr_valid) wait_r <= wait_r + 2'h1;
  end
endmodule : dav_fb_model

// ---- testbench/tb.sv ----
// Bench for the draw-and-advance unit
// Assumes the frame buffer model on the write side
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import dav_pkg::*;
  logic mclk, arst_n, start, file_sel, reg_we, reg_we_file, wr_ready;
  logic wr_valid, busy, done;
  logic [3:0] src_idx, dst_idx, reg_we_idx;
  logic [31:0] reg_wdata, colour, rd_a_dst, rd_b_dst;
  logic [1:0] stall;
  dav_fmt_t fmt;
  dav_pix_t wr_pix, last_pix;
  int failures, checks, i;
  `define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
    $display("Error %0t got %h exp %h", $time, a, b); end end
  dav_unit dut_u (.mclk(mclk), .arst_n(arst_n), .start(start),
    .file_sel(file_sel), .src_idx(src_idx), .dst_idx(dst_idx),
    .reg_we(reg_we), .reg_we_file(reg_we_file), .reg_we_idx(reg_we_idx),
    .reg_wdata(reg_wdata), .foreground_colour_reg(colour), .fmt(fmt),
    .wr_ready(wr_ready), .wr_pix(wr_pix), .wr_valid(wr_valid),
    .busy(busy), .done(done), .rd_a_dst(rd_a_dst), .rd_b_dst(rd_b_dst));
  dav_fb_model fb_u (.mclk(mclk), .arst_n(arst_n), .stall(stall),
    .wr_valid(wr_valid), .wr_pix(wr_pix), .wr_ready(wr_ready),
    .last_r(last_pix));
  task close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task ld(input logic f, input logic [3:0] n, input logic [31:0] v);
    @(posedge mclk);
    {reg_we, reg_we_file, reg_we_idx, reg_wdata} <= {1'b1, f, n, v};
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask : ld
  task run(input logic f, input logic [3:0] s, d, input logic [1:0] st);
    int n;
    @(posedge mclk);
    {file_sel, src_idx, dst_idx, stall, start} <= {f, s, d, st, 1'b1};
    @(posedge mclk);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      #1 n++;
    end while (done !== 1'b1 && n < 20);
    `CHK(done, 1'b1)
    `CHK(busy, 1'b0)
  endtask : run
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // ----------------------------------------
  // Watchdog: 77 runs need under 1000 cycles
  // ----------------------------------------
  initial begin
    #300000;
    failures++;
    close_out();
  end
  initial begin
    {arst_n, start, file_sel, reg_we, reg_we_file, stall} = '0;
    {src_idx, dst_idx, reg_we_idx, reg_wdata} = '0;
    colour = 32'h6666_6666;
    fmt = '{32'h0000_0100, 5'h0c, 6'h04, 16'h00f0};
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    ld(1'b0, 4'h1, 32'h0001_0000);
    ld(1'b0, 4'h2, 32'h001e_0040);
    run(1'b0, 4'h1, 4'h2, 2'h0);
    `CHK(last_pix.addr, 32'h0001_e200)
    `CHK(last_pix.data, 32'h6666_6666)
    `CHK(last_pix.mask, 32'h00f0_00f0)
    `CHK(last_pix.size, 6'h04)
    `CHK(rd_a_dst, 32'h001f_0040)
    for (i = 0; i < 75; i++) run(1'b0, 4'h1, 4'h2, 2'(i % 3));
    `CHK(rd_a_dst, 32'h006a_0040)
    ld(1'b1, 4'h1, 32'h0001_0006);
    ld(1'b1, 4'h2, 32'h0000_fffe);
    run(1'b1, 4'h1, 4'h2, 2'h2);
    `CHK(last_pix.addr, 32'h0004_00f8)
    `CHK(rd_b_dst, 32'h0001_0004)
    `CHK(rd_a_dst, 32'h006a_0040)
    // Reset in the middle of a stalled write
    @(posedge mclk);
    {file_sel, dst_idx, stall, start} <= {1'b0, 4'h2, 2'h2, 1'b1};
    @(posedge mclk);
    start <= 1'b0;
    @(posedge mclk);
    arst_n <= 1'b0;
    @(posedge mclk);
    arst_n <= 1'b1;
    #1 `CHK(busy, 1'b0)
    `CHK(rd_a_dst, DAV_REG_RST)
    close_out();
  end
endmodule : tb
